// >>> bench/pin_source.sv
// Partner model: external source driving the capture pin
`timescale 1ns/1ps
module pin_source
#(
  parameter int HOLD = 2
)
(
  input wire logic mclk_i,
  input wire logic toggle_i,
  output logic pin_o
);
  int unsigned held = HOLD;
  initial pin_o = 1'b0;
  // Toggle on request, never before the level has stood HOLD clocks
  always @(posedge mclk_i)
  begin
    if (toggle_i && held >= HOLD)
    begin
      pin_o <= ~pin_o;
      held <= 0;
    end
    else if (held < HOLD)
      held <= held + 1;
  end
endmodule : pin_source

// >>> bench/tb_top.sv
// Testbench: edge count, edge time, PWM and 16-bit timeout scenarios
`timescale 1ns/1ps
module tb_top;
  import gp_timer_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic pin, tog = 1'b0, set = 1'b0, clr = 1'b0, run_q = 1'b0;
  timer_cfg_t cfg = '0;
  logic [3:0] mask = 4'h0, sclr = 4'h0;
  logic run_enable_o, pwm_o;
  timer_status_t raw_status_o;
  logic [3:0] masked_status_o;
  logic [15:0] counter_o, captured_count_o, c0, cnt_q;
  int n_fail = 0, compares = 0;
  gp_timer_capture_pwm #(.RTC_DIVIDE(4)) gp_timer_capture_pwm_i (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i), .capture_compare_pin_i(pin), .cfg_i(cfg),
    .run_enable_set_i(set), .run_enable_clr_i(clr),
    .interrupt_mask_i(mask), .status_clear_i(sclr),
    .run_enable_o(run_enable_o), .raw_status_o(raw_status_o),
    .masked_status_o(masked_status_o), .counter_o(counter_o),
    .captured_count_o(captured_count_o), .pwm_o(pwm_o));
  pin_source #(.HOLD(2)) pin_source_i (.mclk_i(mclk_i), .toggle_i(tog),
    .pin_o(pin));
  initial forever #50 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Wait n edges then settle at the falling edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : wait_clk
  // Stop, load the configuration, then start last
  task automatic cfg_run(input timer_cfg_t c, input logic [3:0] m);
    @(posedge mclk_i) clr <= 1'b1;
    @(posedge mclk_i) clr <= 1'b0;
    cfg <= c;
    mask <= m;
    @(posedge mclk_i) set <= 1'b1;
    @(posedge mclk_i) set <= 1'b0;
  endtask : cfg_run
  task automatic edge_pin;
    @(posedge mclk_i) tog <= 1'b1;
    @(posedge mclk_i) tog <= 0;
    wait_clk(8);
  endtask : edge_pin
  task automatic clear(input logic [3:0] b);
    @(posedge mclk_i) sclr <= b;
    @(posedge mclk_i) sclr <= 4'h0;
    wait_clk(1);
    check(16'(raw_status_o), 16'h0000);
  endtask : clear
  ////////////////////////////////////////////////////////////////////////
  // Running counter: one step a clock, reload after zero, PWM levels
  always @(negedge mclk_i)
  begin
    if (run_enable_o && run_q && cfg.configuration_select == CFG_16_TIMER
        && (cfg.alternate_mode_select || cfg.capture_mode_select))
    begin
      check(counter_o, cnt_q == COUNT_ZERO ? cfg.interval_load
        : cnt_q - 16'h0001);
      if (cfg.alternate_mode_select)
      begin
        check(16'(raw_status_o), 16'h0000);
        if (cnt_q == cfg.interval_load)
          check(16'(pwm_o), 16'(!cfg.pwm_output_invert));
        if (cnt_q == cfg.match_value)
          check(16'(pwm_o), 16'(cfg.pwm_output_invert));
      end
    end
    cnt_q = counter_o;
    run_q = run_enable_o;
  end
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial
  begin
    timer_cfg_t c;
    cfg.interval_load <= INTERVAL_RESET;
    cfg.match_value <= MATCH_RESET;
    wait_clk(10);
    @(posedge mclk_i) rstn_i <= 1'b1;
    wait_clk(4);
    check(counter_o, INTERVAL_RESET);
    // Edge count: load 0x000A, match 0x0006, both edges
    c = '0;
    c.configuration_select = CFG_16_TIMER;
    c.timer_mode_field = MODE_CAPTURE;
    c.edge_select = EDGE_BOTH;
    c.interval_load = 16'h000A;
    c.match_value = 16'h0006;
    cfg_run(c, 4'h2);
    edge_pin;
    check(counter_o, 16'h0009);
    repeat (3) edge_pin;
    check(16'(raw_status_o), 16'h0002);
    check(16'(masked_status_o), 16'h0002);
    check(16'(run_enable_o), 16'h0000);
    check(counter_o, 16'h000A);
    repeat (2) edge_pin;
    check(counter_o, 16'h000A);
    clear(4'h2);
    // Edge time: rising edges only, prescale must be ignored
    c.capture_mode_select = 1'b1;
    c.edge_select = EDGE_RISE;
    c.interval_load = 16'h0100;
    c.prescale_value = 8'h05;
    cfg_run(c, 4'h1);
    wait_clk(3);
    c0 = counter_o;
    edge_pin;
    check(16'(captured_count_o <= c0 && captured_count_o + 16'h0008 >= c0),
      16'h0001);
    check(16'(raw_status_o), 16'h0001);
    check(16'(masked_status_o), 16'h0001);
    c0 = captured_count_o;
    wait_clk(300);
    edge_pin;
    check(captured_count_o, c0);
    clear(4'h1);
    edge_pin;
    check(16'(captured_count_o != c0), 16'h0001);
    check(16'(raw_status_o), 16'h0001);
    clear(4'h1);
    // PWM in both polarities with pin activity and all masks open
    c.alternate_mode_select = 1'b1;
    c.capture_mode_select = 1'b0;
    c.timer_mode_field = MODE_PERIODIC;
    c.interval_load = 16'h0010;
    c.match_value = 16'h0008;
    for (int inv = 0; inv < 2; inv++)
    begin
      c.pwm_output_invert = inv[0];
      cfg_run(c, 4'hF);
      repeat (6) edge_pin;
    end
    // 16-bit one-shot then periodic timeout
    c = '0;
    c.configuration_select = CFG_16_TIMER;
    c.interval_load = 16'h0008;
    for (int m = 1; m < 3; m++)
    begin
      c.timer_mode_field = 2'(m);
      cfg_run(c, 4'h4);
      for (int i = 0; i < 40 && raw_status_o.timeout_raw_flag !== 1'b1; i++)
        wait_clk(0);
      check(16'(masked_status_o), 16'h0004);
      wait_clk(2);
      check(16'(run_enable_o), 16'(m == 2));
      clear(4'h4);
      wait_clk(20);
      check(16'(raw_status_o), 16'(m == 2 ? 4 : 0));
    end
    // Real-time clock: match 2 after two divided steps from the first count
    c = '0;
    c.configuration_select = CFG_32_RTC;
    c.match_value = 16'h0002;
    cfg_run(c, 4'h8);
    repeat (16) edge_pin;
    check(16'(raw_status_o.rtc_match_raw_flag), 16'h0001);
    check(16'(masked_status_o), 16'h0008);
    check(counter_o, 16'h0000);
    check(16'(run_enable_o), 16'h0001);
    clear(4'hC);
    results;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    results;
  end
endmodule : tb_top

// >>> src/edge_detect.sv
// Edge detector: three-stage synchroniser on the pin plus edge select
`timescale 1ns/1ps
module edge_detect
  import gp_timer_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  input wire logic [1:0] edge_select_i,
  output logic edge_o
);
  logic [SYNC_STAGES-1:0] sync_r;
  logic [SYNC_STAGES-1:0] sync_nxt;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////
  // Shift the pin through the synchroniser
  always_comb
  begin
    sync_nxt = {sync_r[SYNC_STAGES-2:0], pin_i};
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      sync_r <= '0;
    else
      sync_r <= sync_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // A change counts once stage two disagrees with stage three, the past level
  assign rise = sync_r[1] & ~sync_r[2];
  assign fall = ~sync_r[1] & sync_r[2];

  // Select which edges count
  always_comb
  begin
    unique case (edge_select_i)
      EDGE_RISE: edge_o = rise;
      EDGE_FALL: edge_o = fall;
      EDGE_BOTH: edge_o = rise | fall;
      default: edge_o = 1'b0;
    endcase
  end
endmodule : edge_detect

// >>> src/gp_timer_capture_pwm.sv
// Timer half: edge count, edge time capture, PWM and 16-bit timeout modes
//
// Functional notes
// - Edge count: each edge decrements until match
// - Count match sets raw and masked flags
// - After match reload, drop run enable
// - Edge time counts down from interval load
// - Edge time copies count, sets capture flags
// - Edge time keeps counting, reloads at zero
// - No prescaler in capture or PWM mode
// - PWM counts to zero then reloads
// - PWM mode raises no flags
// - PWM active at start, inactive at match
// - Invert bit flips PWM polarity
// - Writing clear bit clears timeout flags
// - RTC match sets RTC raw flag
// - One-shot stops after timeout, periodic continues
`timescale 1ns/1ps
module gp_timer_capture_pwm
  import gp_timer_pkg::*;
#(
  parameter int RTC_DIVIDE = RTC_DIV
)
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic capture_compare_pin_i,
  input wire timer_cfg_t cfg_i,
  input wire logic run_enable_set_i,
  input wire logic run_enable_clr_i,
  input wire logic [3:0] interrupt_mask_i,
  input wire logic [3:0] status_clear_i,
  output logic run_enable_o,
  output timer_status_t raw_status_o,
  output logic [3:0] masked_status_o,
  output logic [15:0] counter_o,
  output logic [15:0] captured_count_o,
  output logic pwm_o
);
  logic edge_seen;
  logic is_16;
  logic pwm_mode;
  logic edge_count_mode;
  logic edge_time_mode;
  logic timer_mode;
  logic run_r;
  logic run_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [7:0] pre_r;
  logic [7:0] pre_nxt;
  logic [15:0] cap_r;
  logic [15:0] cap_nxt;
  logic pwm_r;
  logic pwm_nxt;
  timer_status_t st_r;
  timer_status_t st_nxt;
  timer_status_t set_ev;
  localparam int DIV_W = $clog2(RTC_DIVIDE);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIVIDE - 1);
  logic rtc_mode;
  logic rtc_tick;
  logic [1:0] edge_sel;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the capture pin
  edge_detect u_edge (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .pin_i(capture_compare_pin_i),
    .edge_select_i(edge_sel),
    .edge_o(edge_seen)
  );

  // Mode decode
  assign is_16 = cfg_i.configuration_select[2];
  assign pwm_mode = is_16 && cfg_i.alternate_mode_select;
  assign edge_count_mode = is_16 && !cfg_i.alternate_mode_select &&
                           cfg_i.timer_mode_field == MODE_CAPTURE &&
                           !cfg_i.capture_mode_select;
  assign edge_time_mode = is_16 && !cfg_i.alternate_mode_select &&
                          cfg_i.timer_mode_field == MODE_CAPTURE &&
                          cfg_i.capture_mode_select;
  assign timer_mode = is_16 && !cfg_i.alternate_mode_select &&
                      (cfg_i.timer_mode_field == MODE_ONE_SHOT ||
                       cfg_i.timer_mode_field == MODE_PERIODIC);
  // Real-time mode counts rising edges of the slow clock on the pin
  assign rtc_mode = cfg_i.configuration_select == CFG_32_RTC;
  assign edge_sel = rtc_mode ? EDGE_RISE : cfg_i.edge_select;
  assign rtc_tick = edge_seen && div_r == DIV_LAST;

  ////////////////////////////////////////////////////////////////////////////
  // Counter, prescaler, run enable, capture and PWM next values
  always_comb
  begin
    run_nxt = run_r;
    cnt_nxt = cnt_r;
    pre_nxt = pre_r;
    cap_nxt = cap_r;
    pwm_nxt = pwm_r;
    set_ev = '0;
    div_nxt = div_r;
    if (run_enable_set_i)
      run_nxt = 1'b1;
    if (run_enable_clr_i)
      run_nxt = 1'b0;
    if (run_r)
    begin
      if (edge_count_mode)
      begin
        if (cnt_r == cfg_i.match_value)
        begin
          set_ev.count_match_raw_flag = 1'b1;
          cnt_nxt = cfg_i.interval_load;
          run_nxt = 1'b0;
        end
        else if (edge_seen)
          cnt_nxt = cnt_r - 16'h0001;
      end
      else if (edge_time_mode)
      begin
        if (edge_seen)
        begin
          cap_nxt = cnt_r;
          set_ev.capture_event_raw_flag = 1'b1;
        end
        // Step every clock, no prescaler
        if (cnt_r == COUNT_ZERO)
          cnt_nxt = cfg_i.interval_load;
        else
          cnt_nxt = cnt_r - 16'h0001;
      end
      else if (pwm_mode)
      begin
        // No status is raised here
        if (cnt_r == COUNT_ZERO)
          cnt_nxt = cfg_i.interval_load;
        else
          cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == cfg_i.interval_load)
          pwm_nxt = 1'b1;
        else if (cnt_r == cfg_i.match_value)
          pwm_nxt = 1'b0;
      end
      else if (timer_mode)
      begin
        // Prescaler stretches each counter step
        if (pre_r != PRESCALE_RESET)
          pre_nxt = pre_r - 8'h01;
        else if (cnt_r == COUNT_ZERO)
        begin
          cnt_nxt = cfg_i.interval_load;
          pre_nxt = cfg_i.prescale_value;
          set_ev.timeout_raw_flag = 1'b1;
          if (cfg_i.timer_mode_field == MODE_ONE_SHOT)
            run_nxt = 1'b0;
        end
        else
        begin
          cnt_nxt = cnt_r - 16'h0001;
          pre_nxt = cfg_i.prescale_value;
        end
      end
      else if (rtc_mode)
      begin
        // Divide the slow clock, then count up and roll over at the match
        if (edge_seen)
          div_nxt = rtc_tick ? '0 : div_r + 1'b1;
        if (rtc_tick && cnt_r == cfg_i.match_value)
        begin
          cnt_nxt = COUNT_ZERO;
          set_ev.rtc_match_raw_flag = 1'b1;
        end
        else if (rtc_tick)
          cnt_nxt = cnt_r + 16'h0001;
      end
    end
    else
    begin
      // Idle: preload the start count
      cnt_nxt = rtc_mode ? RTC_FIRST : cfg_i.interval_load;
      pre_nxt = cfg_i.prescale_value;
      pwm_nxt = 1'b0;
      div_nxt = '0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      run_r <= 1'b0;
      cnt_r <= INTERVAL_RESET;
      pre_r <= PRESCALE_RESET;
      cap_r <= COUNT_ZERO;
      pwm_r <= 1'b0;
      div_r <= '0;
    end
    else
    begin
      run_r <= run_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      cap_r <= cap_nxt;
      pwm_r <= pwm_nxt;
      div_r <= div_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: a set in the clearing cycle wins
  always_comb
  begin
    st_nxt = (st_r & ~timer_status_t'(status_clear_i)) | set_ev;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Outputs
  assign run_enable_o = run_r;
  assign raw_status_o = st_r;
  assign masked_status_o = st_r & interrupt_mask_i;
  assign counter_o = cnt_r;
  assign captured_count_o = cap_r;
  assign pwm_o = pwm_r ^ cfg_i.pwm_output_invert;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  match_stops_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    run_r && edge_count_mode && cnt_r == cfg_i.match_value &&
    !run_enable_set_i |=> !run_r && st_r.count_match_raw_flag)
    else $error("count match did not stop timer");
  count_step_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    run_r && edge_count_mode && cnt_r != cfg_i.match_value && edge_seen
    && !run_enable_clr_i |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("edge did not decrement count");
  capture_copy_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    run_r && edge_time_mode && edge_seen |=>
    cap_r == $past(cnt_r) && st_r.capture_event_raw_flag)
    else $error("capture value wrong");
  time_reload_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    run_r && (edge_time_mode || pwm_mode) && cnt_r == COUNT_ZERO
    |=> cnt_r == $past(cfg_i.interval_load))
    else $error("reload at zero missing");
  pwm_no_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    pwm_mode && $stable(pwm_mode) |=> st_r == $past(st_r) ||
    (st_r & ~$past(st_r)) == '0)
    else $error("flag set in pwm mode");
  pwm_high_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    run_r && run_nxt && pwm_mode && cnt_r == cfg_i.interval_load
    |=> pwm_r)
    else $error("pwm not active at start");
  clear_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    status_clear_i[1] && !set_ev.count_match_raw_flag
    |=> !st_r.count_match_raw_flag)
    else $error("flag not cleared");
  one_shot_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    set_ev.timeout_raw_flag && cfg_i.timer_mode_field == MODE_ONE_SHOT
    && !run_enable_set_i |=> !run_r)
    else $error("one-shot kept running");
  rtc_match_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    run_r && rtc_mode && rtc_tick && cnt_r == cfg_i.match_value
    |=> st_r.rtc_match_raw_flag && cnt_r == COUNT_ZERO)
    else $error("rtc match not flagged");
endmodule : gp_timer_capture_pwm

// >>> src/gp_timer_pkg.sv
// Package: constants and carrier types for the timer half
package gp_timer_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] INTERVAL_RESET = 16'hFFFF;
  localparam logic [15:0] MATCH_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [2:0] CFG_32_TIMER = 3'h0;
  localparam logic [2:0] CFG_32_RTC = 3'h1;
  localparam logic [2:0] CFG_16_TIMER = 3'h4;
  localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam int SYNC_STAGES = 3;
  // Slow-clock edges per real-time step, and the first real-time count
  localparam int RTC_DIV = 32768;
  localparam logic [15:0] RTC_FIRST = 16'h0001;

  // Software configuration, steady while run enable is high
  typedef struct packed {
    logic [2:0] configuration_select;
    logic [1:0] timer_mode_field;
    logic capture_mode_select;
    logic alternate_mode_select;
    logic [1:0] edge_select;
    logic pwm_output_invert;
    logic [15:0] interval_load;
    logic [15:0] match_value;
    logic [7:0] prescale_value;
  } timer_cfg_t;

  // Sticky raw status flags
  typedef struct packed {
    logic rtc_match_raw_flag;
    logic timeout_raw_flag;
    logic count_match_raw_flag;
    logic capture_event_raw_flag;
  } timer_status_t;
endpackage : gp_timer_pkg
